/* hdl/cfgload_pkg.sv */
/*
  Shared constants of the configuration word loader: the serial memory word map,
  store indices, configuration offsets, field positions and the bus address layout.
  Assumes a 32-bit APB register bus and a 16-bit word reader for the serial memory.
*/
package cfgload_pkg;
  localparam int NWORDS = 16;
  localparam int IXW    = 4;
  localparam int EE_AW  = 8;
  localparam int WORD_W = 16;
  localparam int AW     = 13;
  localparam int DW     = 32;
  localparam int OFF_W  = 10;
  localparam int SP_W   = 3;
  // serial memory word addresses, in load order
  localparam logic [EE_AW-1:0] EE_MAP [NWORDS] = '{
    8'h22, 8'h24, 8'h28, 8'h2A, 8'h2C, 8'h2E, 8'h32, 8'h34,
    8'h38, 8'h3A, 8'h3C, 8'h3E, 8'h42, 8'h44, 8'h48, 8'h4A};
  // store indices
  localparam int IX_P1      = 0;
  localparam int IX_P2      = 1;
  localparam int IX_VID0    = 2;
  localparam int IX_DEVCTL0 = 5;
  localparam int IX_SLOT1_L = 6;
  localparam int IX_SLOT2_L = 7;
  localparam int IX_DID0    = 8;
  localparam int IX_MISC2   = 11;
  localparam int IX_SLOT1_H = 12;
  localparam int IX_SLOT2_H = 13;
  localparam int IX_REV0    = 14;
  // address spaces, selected by address bits above the offset
  localparam logic [SP_W-1:0] SP_FUNC0  = 3'h0;
  localparam logic [SP_W-1:0] SP_FUNC2  = 3'h2;
  localparam logic [SP_W-1:0] SP_PORT1  = 3'h3;
  localparam logic [SP_W-1:0] SP_PORT2  = 3'h4;
  localparam logic [SP_W-1:0] SP_LOADER = 3'h5;
  // configuration offsets
  localparam logic [OFF_W-1:0] OFF_ID      = 10'h000;
  localparam logic [OFF_W-1:0] OFF_REV     = 10'h008;
  localparam logic [OFF_W-1:0] OFF_MISC    = 10'h068;
  localparam logic [OFF_W-1:0] OFF_DSI     = 10'h080;
  localparam logic [OFF_W-1:0] OFF_PMCSR   = 10'h084;
  localparam logic [OFF_W-1:0] OFF_CAP     = 10'h0E0;
  localparam logic [OFF_W-1:0] OFF_DEVCTL  = 10'h0E8;
  localparam logic [OFF_W-1:0] OFF_PORTNUM = 10'h0EC;
  localparam logic [OFF_W-1:0] OFF_SLOTCLK = 10'h0F0;
  localparam logic [OFF_W-1:0] OFF_SLOTCAP = 10'h0F4;
  localparam logic [OFF_W-1:0] OFF_TCMAP   = 10'h154;
  localparam logic [OFF_W-1:0] OFF_LDCTRL  = 10'h000;
  localparam logic [OFF_W-1:0] OFF_LDSTAT  = 10'h004;
  // field positions: source bit in word, destination bit in dword, width
  localparam int SRC_SLOTIMP = 0;
  localparam int DST_SLOTIMP = 24;
  localparam int SRC_REFCLK  = 1;
  localparam int DST_REFCLK  = 28;
  localparam int SRC_DSI     = 2;
  localparam int DST_DSI     = 21;
  localparam int SRC_PNUM    = 4;
  localparam int DST_PNUM    = 24;
  localparam int PNUM_W      = 2;
  localparam int SRC_PMSC    = 6;
  localparam int DST_PMSC    = 13;
  localparam int PMSC_W      = 2;
  localparam int SRC_TC      = 9;
  localparam int DST_TC      = 1;
  localparam int TC_W        = 7;
  localparam int DEVCTL_W    = 15;
  localparam int ERR_W       = 4;
  localparam int MRRS_LSB    = 12;
  localparam int MRRS_W      = 3;
  localparam int MISC_BASIC  = 0;
  localparam int MISC_B64    = 1;
  localparam int MISC_PF     = 2;
  localparam int MISC_UMEN   = 4;
  localparam int MISC_UM_LSB = 5;
  localparam int UMRRS_W     = 2;
  localparam int MISC_PFL    = 8;
  localparam int PFL_W       = 7;
  localparam logic [WORD_W-1:0] MISC_MASK = 16'h7F77;
  // loader control and status bits
  localparam int CTL_RELOAD  = 0;
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_IDX      = 8;
endpackage

/* hdl/cfg_word_store.sv */
/*
  Register bank holding the loaded configuration words, all readable in parallel.
  Assumes one write per cycle from the loader; every word reads zero after reset.
*/
`timescale 1ns/1ps
module cfg_word_store #(
  parameter int N = cfgload_pkg::NWORDS,
  parameter int W = cfgload_pkg::WORD_W,
  parameter int XW = cfgload_pkg::IXW
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // write port
  input  wire logic         we,
  input  wire logic [XW-1:0] widx,
  input  wire logic [W-1:0] wdata,
  // parallel read
  output logic      [W-1:0] words [N]
);
  import cfgload_pkg::*;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) begin
        words[i] <= '0;
      end
    end else if (we) begin
      words[widx] <= wdata;
    end
  end
endmodule

/* hdl/ee_word_fetch.sv */
/*
  Walks the serial memory word map, reads each word and writes it to the store.
  Assumes a word reader on the same clock that answers a held request with a
  one-cycle acknowledge carrying the data.
*/
`timescale 1ns/1ps
module ee_word_fetch (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // control
  input  wire logic                          start,
  output logic                               busy,
  output logic [cfgload_pkg::IXW-1:0]        idx,
  // word reader
  output logic                               req,
  output logic [cfgload_pkg::EE_AW-1:0]      addr,
  input  wire logic                          ack,
  input  wire logic [cfgload_pkg::WORD_W-1:0] rdata,
  // store write
  output logic                               we,
  output logic [cfgload_pkg::IXW-1:0]        widx,
  output logic [cfgload_pkg::WORD_W-1:0]     wdata
);
  import cfgload_pkg::*;

  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_GAP} fetch_t;
  fetch_t state;

  assign busy = (state != F_IDLE) || we;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= F_IDLE;
      idx   <= '0;
      req   <= 1'b0;
      addr  <= '0;
      we    <= 1'b0;
      widx  <= '0;
      wdata <= '0;
    end else begin
      we <= 1'b0;
      unique case (state)
        F_IDLE: if (start) begin
          idx   <= '0;
          addr  <= EE_MAP[0];
          req   <= 1'b1;
          state <= F_WAIT;
        end
        F_WAIT: if (ack) begin
          req   <= 1'b0;
          we    <= 1'b1;
          widx  <= idx;
          wdata <= rdata;
          if (idx == IXW'(NWORDS - 1)) begin
            state <= F_IDLE;
          end else begin
            idx   <= IXW'(idx + 1'b1);
            state <= F_GAP;
          end
        end
        F_GAP: begin
          addr  <= EE_MAP[idx];
          req   <= 1'b1;
          state <= F_WAIT;
        end
      endcase
    end
  end
endmodule

/* hdl/cfg_word_loader.sv */
/*
  Configuration word loader: fetches words 22h..4Ah from the serial memory after
  reset, places their fields in the configuration space of ports 1-2 and
  functions 0-2, and serves that space read-only over APB.
  Assumes an APB master on CLK_SYS and a word reader on the same clock.
//
// Summary of operation
// - word 22h 15:9 to port 1 TC map
// - word 24h bit 0 to slot implemented
// - word 24h bit 1 to slot clock
// - word 24h bit 2 to DSI required
// - word 24h 5:4 to port number
// - word 24h 7:6 to PM data scale
// - word 24h 15:9 to port 2 TC map
// - vendor ids from words 28h, 2Ah, 2Ch
// - word 2Eh 3:0 error reporting enables
// - word 2Eh 14:4 device control fields
// - port 1 slot capability from 32h, 42h
// - port 2 slot capability from 34h, 44h
// - device ids from words 38h, 3Ah, 3Ch
// - word 3Eh function 2 mode enables
// - user read request size overrides standard
// - prefetch length from word 3Eh 14:8
// - revision and interface from 48h, 4Ah
*/
`timescale 1ns/1ps
module cfg_word_loader (
  // clock and reset
  input  wire logic                           CLK_SYS,
  input  wire logic                           RST_B,
  // apb slave
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [cfgload_pkg::AW-1:0]     PADDR,
  input  wire logic [cfgload_pkg::DW-1:0]     PWDATA,
  output logic      [cfgload_pkg::DW-1:0]     PRDATA,
  output logic                                PREADY,
  output logic                                PSLVERR,
  // serial memory word reader
  output logic                                EE_RD_REQ,
  output logic      [cfgload_pkg::EE_AW-1:0]  EE_WORD_ADDR,
  input  wire logic                           EE_RD_ACK,
  input  wire logic [cfgload_pkg::WORD_W-1:0] EE_RD_DATA,
  // load state
  output logic                                LOAD_BUSY,
  output logic                                LOAD_DONE,
  // port settings
  output logic      [cfgload_pkg::TC_W-1:0]   P1_TC_VC0_MAP,
  output logic      [cfgload_pkg::TC_W-1:0]   P2_TC_VC0_MAP,
  output logic                                P2_SLOT_IMPL,
  output logic                                P2_SLOT_CLK,
  output logic                                P2_DSI_REQ,
  output logic      [cfgload_pkg::PNUM_W-1:0] P2_PORT_NUM,
  output logic      [cfgload_pkg::PMSC_W-1:0] P2_PM_DATA_SCALE,
  // function settings
  output logic      [cfgload_pkg::ERR_W-1:0]  F0_ERR_REPORT_EN,
  output logic                                F2_BASIC_MODE,
  output logic                                F2_BOUNDARY64,
  output logic                                F2_HC_PREFETCH,
  output logic      [cfgload_pkg::PFL_W-1:0]  PREFETCH_LENGTH_DWORDS,
  output logic      [cfgload_pkg::MRRS_W-1:0] F2_MAX_READ_REQ
);
  import cfgload_pkg::*;

  logic [WORD_W-1:0] w [NWORDS];
  logic              boot;
  logic              start;
  logic              busy;
  logic              loaded;
  logic [IXW-1:0]    idx;
  logic              we;
  logic [IXW-1:0]    widx;
  logic [WORD_W-1:0] wdata;
  logic              answer;
  logic              acc;
  logic              wr_ctrl;
  logic [SP_W-1:0]   space;
  logic [OFF_W-1:0]  off;
  logic [DW-1:0]     rd_val;
  logic              rd_hit;
  logic [WORD_W-1:0] misc;

  // field placement: take wid bits at src of a word, put them at dst of a dword
  function automatic logic [DW-1:0] put(input logic [WORD_W-1:0] v, input int src, input int dst,
                                        input int wid);
    logic [DW-1:0] m;
    m   = DW'((64'h1 << wid) - 64'h1);
    put = ((DW'(v) >> src) & m) << dst;
  endfunction

  cfg_word_store u_store (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .we    (we),
    .widx  (widx),
    .wdata (wdata),
    .words (w)
  );

  ee_word_fetch u_fetch (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .start (start),
    .busy  (busy),
    .idx   (idx),
    .req   (EE_RD_REQ),
    .addr  (EE_WORD_ADDR),
    .ack   (EE_RD_ACK),
    .rdata (EE_RD_DATA),
    .we    (we),
    .widx  (widx),
    .wdata (wdata)
  );

  // automatic load right after reset release, or on software request
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  assign wr_ctrl = acc && PREADY && PWRITE && (space == SP_LOADER) && (off == OFF_LDCTRL);
  assign start   = boot || (wr_ctrl && PWDATA[CTL_RELOAD] && !busy);

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      loaded <= 1'b0;
    end else if (start) begin
      loaded <= 1'b0;
    end else if (!busy) begin
      loaded <= 1'b1;
    end
  end

  assign LOAD_BUSY = busy || !loaded;
  assign LOAD_DONE = loaded;

  // apb: one wait state, more while a load is running
  assign acc   = PSEL && PENABLE;
  assign space = PADDR[OFF_W +: SP_W];
  assign off   = PADDR[OFF_W-1:0];
  assign misc  = w[IX_MISC2] & MISC_MASK;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      answer <= 1'b0;
    end else begin
      answer <= acc && !LOAD_BUSY && !answer;
    end
  end

  assign PREADY = answer;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else if (acc && !LOAD_BUSY && !answer) begin
      PRDATA  <= PWRITE ? '0 : rd_val;
      PSLVERR <= !rd_hit;
    end
  end

  // configuration space read decode
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (space)
      SP_FUNC0, SP_FUNC0 + 3'h1, SP_FUNC2: begin
        if (off == OFF_ID) begin
          rd_val = {w[IX_DID0 + int'(space)], w[IX_VID0 + int'(space)]};
        end else if (off == OFF_REV && space != SP_FUNC2) begin
          rd_val = DW'(w[IX_REV0 + int'(space)]);
        end else if (off == OFF_DEVCTL && space == SP_FUNC0) begin
          rd_val = put(w[IX_DEVCTL0], 0, 0, DEVCTL_W);
        end else if (off == OFF_MISC && space == SP_FUNC2) begin
          rd_val = DW'(misc);
        end else begin
          rd_hit = 1'b0;
        end
      end
      SP_PORT1: begin
        if (off == OFF_TCMAP) begin
          rd_val = put(w[IX_P1], SRC_TC, DST_TC, TC_W);
        end else if (off == OFF_SLOTCAP) begin
          rd_val = {w[IX_SLOT1_H], w[IX_SLOT1_L]};
        end else begin
          rd_hit = 1'b0;
        end
      end
      SP_PORT2: begin
        unique case (off)
          OFF_CAP:     rd_val = put(w[IX_P2], SRC_SLOTIMP, DST_SLOTIMP, 1);
          OFF_SLOTCLK: rd_val = put(w[IX_P2], SRC_REFCLK, DST_REFCLK, 1);
          OFF_DSI:     rd_val = put(w[IX_P2], SRC_DSI, DST_DSI, 1);
          OFF_PORTNUM: rd_val = put(w[IX_P2], SRC_PNUM, DST_PNUM, PNUM_W);
          OFF_PMCSR:   rd_val = put(w[IX_P2], SRC_PMSC, DST_PMSC, PMSC_W);
          OFF_TCMAP:   rd_val = put(w[IX_P2], SRC_TC, DST_TC, TC_W);
          OFF_SLOTCAP: rd_val = {w[IX_SLOT2_H], w[IX_SLOT2_L]};
          default:     rd_hit = 1'b0;
        endcase
      end
      SP_LOADER: begin
        if (off == OFF_LDCTRL) begin
          rd_val = '0;
        end else if (off == OFF_LDSTAT) begin
          rd_val[ST_BUSY]          = busy;
          rd_val[ST_DONE]          = loaded;
          rd_val[ST_IDX +: IXW]    = idx;
        end else begin
          rd_hit = 1'b0;
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // port settings to the link logic
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      P1_TC_VC0_MAP    <= '0;
      P2_TC_VC0_MAP    <= '0;
      P2_SLOT_IMPL     <= 1'b0;
      P2_SLOT_CLK      <= 1'b0;
      P2_DSI_REQ       <= 1'b0;
      P2_PORT_NUM      <= '0;
      P2_PM_DATA_SCALE <= '0;
    end else begin
      P1_TC_VC0_MAP    <= w[IX_P1][SRC_TC +: TC_W];
      P2_TC_VC0_MAP    <= w[IX_P2][SRC_TC +: TC_W];
      P2_SLOT_IMPL     <= w[IX_P2][SRC_SLOTIMP];
      P2_SLOT_CLK      <= w[IX_P2][SRC_REFCLK];
      P2_DSI_REQ       <= w[IX_P2][SRC_DSI];
      P2_PORT_NUM      <= w[IX_P2][SRC_PNUM +: PNUM_W];
      P2_PM_DATA_SCALE <= w[IX_P2][SRC_PMSC +: PMSC_W];
    end
  end

  // function settings to the host controller logic
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      F0_ERR_REPORT_EN       <= '0;
      F2_BASIC_MODE          <= 1'b0;
      F2_BOUNDARY64          <= 1'b0;
      F2_HC_PREFETCH         <= 1'b0;
      PREFETCH_LENGTH_DWORDS <= '0;
      F2_MAX_READ_REQ        <= '0;
    end else begin
      F0_ERR_REPORT_EN       <= w[IX_DEVCTL0][ERR_W-1:0];
      F2_BASIC_MODE          <= misc[MISC_BASIC];
      F2_BOUNDARY64          <= misc[MISC_B64];
      F2_HC_PREFETCH         <= misc[MISC_PF];
      PREFETCH_LENGTH_DWORDS <= misc[MISC_PFL +: PFL_W];
      if (misc[MISC_UMEN]) begin
        F2_MAX_READ_REQ <= MRRS_W'(misc[MISC_UM_LSB +: UMRRS_W]);
      end else begin
        F2_MAX_READ_REQ <= w[IX_DEVCTL0][MRRS_LSB +: MRRS_W];
      end
    end
  end
endmodule

/* sim/ee_word_model.sv */
/*
  Word reader model of the serial memory: answers each held request with a
  one-cycle acknowledge after lat idle cycles.
  Assumes the loader's clock and reset; content is the address pattern xor salt, with bit 3 of word 3Eh cleared.
*/
`timescale 1ns/1ps
module ee_word_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // word reader
  input  wire logic        req,
  input  wire logic [7:0]  addr,
  output logic             ack,
  output logic [15:0]      data,
  // content and pace
  input  wire logic [15:0] salt,
  input  wire logic [3:0]  lat
);
  logic [3:0] cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack  <= 1'b0;
      cnt  <= 4'h0;
      data <= 16'h0000;
    end else begin
      ack <= 1'b0;
      if (ack) begin
        data <= ~data;
      end else if (req && cnt >= lat) begin
        ack  <= 1'b1;
        cnt  <= 4'h0;
        data <= ({addr, addr} ^ salt) & ((addr == 8'h3E) ? 16'hFFF7 : 16'hFFFF);
      end else if (req) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* sim/cfg_word_loader_properties.sv */
/*
  Port checks of the configuration word loader.
  Assumes binding to the loader top; words are captured as the reader returns them.
*/
`timescale 1ns/1ps
module cfg_word_loader_properties (
  // clock and reset
  input wire logic                           CLK_SYS,
  input wire logic                           RST_B,
  // apb and load state
  input wire logic                           PREADY,
  input wire logic                           LOAD_BUSY,
  // word reader
  input wire logic                           EE_RD_REQ,
  input wire logic [cfgload_pkg::EE_AW-1:0]  EE_WORD_ADDR,
  input wire logic                           EE_RD_ACK,
  input wire logic [cfgload_pkg::WORD_W-1:0] EE_RD_DATA,
  // settings
  input wire logic [cfgload_pkg::TC_W-1:0]   P1_TC_VC0_MAP,
  input wire logic [cfgload_pkg::TC_W-1:0]   P2_TC_VC0_MAP,
  input wire logic                           P2_SLOT_IMPL,
  input wire logic                           P2_SLOT_CLK,
  input wire logic                           P2_DSI_REQ,
  input wire logic [cfgload_pkg::PNUM_W-1:0] P2_PORT_NUM,
  input wire logic [cfgload_pkg::PMSC_W-1:0] P2_PM_DATA_SCALE,
  input wire logic [cfgload_pkg::ERR_W-1:0]  F0_ERR_REPORT_EN,
  input wire logic                           F2_BASIC_MODE,
  input wire logic                           F2_BOUNDARY64,
  input wire logic                           F2_HC_PREFETCH,
  input wire logic [cfgload_pkg::PFL_W-1:0]  PREFETCH_LENGTH_DWORDS,
  input wire logic [cfgload_pkg::MRRS_W-1:0] F2_MAX_READ_REQ
);
  import cfgload_pkg::*;
  logic [WORD_W-1:0] w22, w24, w2e, w3e;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  // captured words as handed over by the reader
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      w22 <= '0;
      w24 <= '0;
      w2e <= '0;
      w3e <= '0;
    end else if (EE_RD_REQ && EE_RD_ACK) begin
      case (EE_WORD_ADDR)
        8'h22: w22 <= EE_RD_DATA;
        8'h24: w24 <= EE_RD_DATA;
        8'h2E: w2e <= EE_RD_DATA;
        8'h3E: w3e <= EE_RD_DATA;
        default: ;
      endcase
    end
  end

  sequence s_settled;
    !LOAD_BUSY && !$past(LOAD_BUSY) && !$past(LOAD_BUSY, 2);
  endsequence
  sequence s_waiting;
    EE_RD_REQ && !EE_RD_ACK;
  endsequence

  AST_REQ_HOLD: assert property (s_waiting |=> EE_RD_REQ && $stable(EE_WORD_ADDR))
    else $error("word request moved before ack");
  AST_REQ_DROP: assert property (EE_RD_REQ && EE_RD_ACK |=> !EE_RD_REQ)
    else $error("word request kept after ack");
  AST_READY_AFTER_LOAD: assert property (PREADY |-> !$past(LOAD_BUSY))
    else $error("access answered while loading");
  AST_P1_TC: assert property (s_settled |-> P1_TC_VC0_MAP == w22[15:9])
    else $error("port 1 tc map wrong");
  AST_P2_FLAGS: assert property (s_settled |-> {P2_DSI_REQ, P2_SLOT_CLK, P2_SLOT_IMPL} == w24[2:0])
    else $error("port 2 flags wrong");
  AST_P2_FIELDS: assert property (s_settled |->
    {P2_TC_VC0_MAP, P2_PM_DATA_SCALE, P2_PORT_NUM} == {w24[15:9], w24[7:4]})
    else $error("port 2 fields wrong");
  AST_ERR_EN: assert property (s_settled |-> F0_ERR_REPORT_EN == w2e[3:0])
    else $error("error enables wrong");
  AST_F2_MODES: assert property (s_settled |-> {F2_HC_PREFETCH, F2_BOUNDARY64, F2_BASIC_MODE} == w3e[2:0])
    else $error("function 2 modes wrong");
  AST_PF_LEN: assert property (s_settled |-> PREFETCH_LENGTH_DWORDS == w3e[14:8])
    else $error("prefetch length wrong");
  AST_MRRS: assert property (s_settled |->
    F2_MAX_READ_REQ == (w3e[4] ? {1'b0, w3e[6:5]} : w2e[14:12]))
    else $error("read request size wrong");
endmodule

/* sim/cfg_word_loader_bench.sv */
/*
  Bench of the configuration word loader: boot, refused writes, reloads at
  several paces and contents, reset in mid-load, checked over APB and at the loader ports.
  Assumes the loader, its package, the word reader model and the checker.
*/
`timescale 1ns/1ps
module cfg_word_loader_bench;
  import cfgload_pkg::*;
  logic              clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, req, ack, busy, done;
  logic              impl, sclk, dsi, bmode, b64, hcpf;
  logic [AW-1:0]     paddr;
  logic [DW-1:0]     pwdata, prdata;
  logic [EE_AW-1:0]  waddr;
  logic [WORD_W-1:0] rdata, salt;
  logic [3:0]        lat;
  logic [TC_W-1:0]   tc1, tc2;
  logic [1:0]        pnum, pmsc;
  logic [ERR_W-1:0]  erren;
  logic [PFL_W-1:0]  pfl;
  logic [MRRS_W-1:0] mrrs;
  int                mismatches, check_count, k;

  cfg_word_loader dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EE_RD_REQ(req),
    .EE_WORD_ADDR(waddr), .EE_RD_ACK(ack), .EE_RD_DATA(rdata), .LOAD_BUSY(busy), .LOAD_DONE(done),
    .P1_TC_VC0_MAP(tc1), .P2_TC_VC0_MAP(tc2), .P2_SLOT_IMPL(impl), .P2_SLOT_CLK(sclk), .P2_DSI_REQ(dsi),
    .P2_PORT_NUM(pnum), .P2_PM_DATA_SCALE(pmsc), .F0_ERR_REPORT_EN(erren), .F2_BASIC_MODE(bmode),
    .F2_BOUNDARY64(b64), .F2_HC_PREFETCH(hcpf), .PREFETCH_LENGTH_DWORDS(pfl), .F2_MAX_READ_REQ(mrrs));
  ee_word_model mem (.clk(clk_sys), .rst_b(rst_b), .req(req), .addr(waddr), .ack(ack), .data(rdata),
    .salt(salt), .lat(lat));

  function automatic logic [15:0] ew(input logic [7:0] a);
    ew = {a, a} ^ salt;
    if (a == 8'h3E) begin
      ew[3] = 1'b0;
    end
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [2:0] sp, input logic [9:0] off, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, {sp, off}, 32'h0, r, e);
    chk(r & m, x & m);
    chk(32'(e), 32'h0);
  endtask

  task automatic t_map();
    logic [15:0] w, w2, w3;
    w = ew(8'h24);
    w2 = ew(8'h2E);
    w3 = ew(8'h3E);
    for (int f = 0; f < 3; f++) begin
      rdchk(3'(f), OFF_ID, '1, {ew(8'h38 + 8'(2 * f)), ew(8'h28 + 8'(2 * f))});
    end
    for (int f = 0; f < 2; f++) begin
      rdchk(3'(f), OFF_REV, 32'hFFFF, 32'(ew(8'h48 + 8'(2 * f))));
    end
    rdchk(SP_FUNC0, OFF_DEVCTL, 32'h7FFF, 32'(w2));
    rdchk(SP_FUNC2, OFF_MISC, 32'hFFFF, 32'(w3) & 32'h7F77);
    rdchk(SP_PORT1, OFF_TCMAP, 32'hFE, 32'(ew(8'h22)) >> 8);
    rdchk(SP_PORT1, OFF_SLOTCAP, '1, {ew(8'h42), ew(8'h32)});
    rdchk(SP_PORT2, OFF_SLOTCAP, '1, {ew(8'h44), ew(8'h34)});
    rdchk(SP_PORT2, OFF_CAP, 32'h0100_0000, 32'(w[0]) << 24);
    rdchk(SP_PORT2, OFF_SLOTCLK, 32'h1000_0000, 32'(w[1]) << 28);
    rdchk(SP_PORT2, OFF_DSI, 32'h0020_0000, 32'(w[2]) << 21);
    rdchk(SP_PORT2, OFF_PORTNUM, 32'h0300_0000, 32'(w[5:4]) << 24);
    rdchk(SP_PORT2, OFF_PMCSR, 32'h6000, 32'(w[7:6]) << 13);
    rdchk(SP_PORT2, OFF_TCMAP, 32'hFE, 32'(w) >> 8);
    chk(32'(mrrs), w3[4] ? 32'(w3[6:5]) : 32'(w2[14:12]));
    chk(32'(pfl), 32'(w3[14:8]));
  endtask

  task automatic t_refuse();
    logic [31:0] r;
    logic        e;
    apb(1'b1, {SP_FUNC0, OFF_ID}, 32'hFFFF_FFFF, r, e);
    chk(r | 32'(e), 32'h0);
    rdchk(SP_FUNC0, OFF_ID, '1, {ew(8'h38), ew(8'h28)});
    apb(1'b0, 13'h1C00, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    $display("refuse done");
  endtask

  task automatic t_reload(input logic [15:0] s, input logic [3:0] l);
    logic [31:0] r;
    logic        e;
    int          n;
    salt <= s;
    lat <= l;
    apb(1'b1, {SP_LOADER, OFF_LDCTRL}, 32'h1, r, e);
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    chk(32'(busy), 32'h1);
    t_map();
    apb(1'b0, {SP_LOADER, OFF_LDSTAT}, 32'h0, r, e);
    chk(r & 32'h3, 32'h2);
    chk(32'(done), 32'h1);
    $display("reload %h done", s);
  endtask

  task automatic t_midreset();
    logic [31:0] r;
    logic        e;
    apb(1'b1, {SP_LOADER, OFF_LDCTRL}, 32'h1, r, e);
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({busy, req, done, 22'h0, tc1}, 32'h8000_0000);
    rst_b <= 1'b1;
    t_map();
    $display("mid reset done");
  endtask

  // reader addresses follow the word map in order
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      k <= 0;
    end else if (req && ack) begin
      chk(32'(waddr), 32'(EE_MAP[k]));
      k <= (k + 1) % NWORDS;
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #800000;
    mismatches++;
    close_out();
  end

  initial begin
    {rst_b, psel, penable, pwrite} = 4'h0;
    paddr = '0;
    pwdata = '0;
    salt = 16'h0000;
    lat = 4'h0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_map();
    $display("boot done");
    t_refuse();
    t_reload(16'hFFFF, 4'h3);
    t_reload(16'h5AC3, 4'h1);
    t_midreset();
    close_out();
  end
endmodule

bind cfg_word_loader cfg_word_loader_properties props (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .PREADY(PREADY),
  .LOAD_BUSY(LOAD_BUSY), .EE_RD_REQ(EE_RD_REQ), .EE_WORD_ADDR(EE_WORD_ADDR), .EE_RD_ACK(EE_RD_ACK),
  .EE_RD_DATA(EE_RD_DATA), .P1_TC_VC0_MAP(P1_TC_VC0_MAP), .P2_TC_VC0_MAP(P2_TC_VC0_MAP),
  .P2_SLOT_IMPL(P2_SLOT_IMPL), .P2_SLOT_CLK(P2_SLOT_CLK), .P2_DSI_REQ(P2_DSI_REQ), .P2_PORT_NUM(P2_PORT_NUM),
  .P2_PM_DATA_SCALE(P2_PM_DATA_SCALE), .F0_ERR_REPORT_EN(F0_ERR_REPORT_EN), .F2_BASIC_MODE(F2_BASIC_MODE),
  .F2_BOUNDARY64(F2_BOUNDARY64), .F2_HC_PREFETCH(F2_HC_PREFETCH),
  .PREFETCH_LENGTH_DWORDS(PREFETCH_LENGTH_DWORDS), .F2_MAX_READ_REQ(F2_MAX_READ_REQ));
